//--- rtl/tg_chg_win.v
/*
 * Change window timer: opens on a request, closes by itself.
 * Assumes open_req is a one-cycle strobe in the sys_clk domain.
 */
`timescale 1ns/1ps
`include "tg_consts.vh"

module tg_chg_win (
    sys_clk,
    nrst,
    open_req,
    sys_rst,
    win_open
);
    input wire sys_clk;
    input wire nrst;
    input wire open_req;
    input wire sys_rst;
    output wire win_open;

    reg [2:0] left_r;
    reg [2:0] left_nxt;

    // ---------------------------------------------------------------
    // Countdown
    // ---------------------------------------------------------------
    always @* begin
        left_nxt = left_r;
        if (left_r != 3'h0) begin
            left_nxt = left_r - 3'h1;
        end
        if (open_req) begin
            left_nxt = `TG_CHG_CYCLES;
        end
        if (sys_rst) begin
            left_nxt = 3'h0;
        end
    end

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            left_r <= 3'h0;
        end else begin
            left_r <= left_nxt;
        end
    end

    assign win_open = (left_r != 3'h0);

endmodule

//--- rtl/tg_consts.vh
/*
 * Constants for the timeout guard and its reset-cause register.
 * Assumes an 8-bit register port and a 10 MHz system clock.
 */
// How it works
// - Counter advances on each 128 kHz oscillator tick, acts at the timeout.
// - Restart strobe clears the count; no restart in time means action.
// - Interrupt-only mode raises the interrupt line, never a reset.
// - Reset-only mode pulses the system reset output on expiry.
// - Combined mode interrupts first, then the next expiry resets.
// - Timeout selectable from about 16 ms to about 8 s.
// - Force fuse locks reset enable at one, interrupt enable at zero.
// - After a guard reset the guard stays enabled.
// - Bit 4 set by scan-chain reset; cleared by power-up or zero.
// - Bit 3 set by guard reset; cleared by power-up or zero.
// - Bit 2 set by undervolt reset; cleared by power-up or zero.
// - Bit 1 set by pin reset; cleared by power-up or zero.
// - Bit 0 set on power-up; only a written zero clears it.
// - Change enable clears itself four clock cycles after being set.
// - Reset enable reads and acts as one while guard reset flag set.
// - Period code n gives 2048 times two to n ticks, codes 0 to 9.
// - Interrupt acknowledge clears flag and interrupt enable in combined mode.
`ifndef TG_CONSTS_VH
`define TG_CONSTS_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define TG_CAUSE_OFS 8'h35
`define TG_CTRL_OFS 8'h60

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define TG_IRQ_FLAG_BIT 7
`define TG_IRQ_EN_BIT 6
`define TG_PER_HI_BIT 5
`define TG_CHG_EN_BIT 4
`define TG_RST_EN_BIT 3
`define TG_PER_LO_MSB 2

// ---------------------------------------------------------------
// Cause register fields; cause and control register reset values
// ---------------------------------------------------------------
`define TG_SCAN_BIT 4
`define TG_GUARD_BIT 3
`define TG_UNDERVOLT_BIT 2
`define TG_PIN_BIT 1
`define TG_POWERUP_BIT 0
`define TG_CAUSE_W 5
`define TG_CAUSE_RST 5'h01
`define TG_CTRL_RST_EN 1'b0
`define TG_PER_RST 4'h0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define TG_OSC_KHZ 128
`define TG_TOUT_BASE 21'h000800
`define TG_PER_MAX 4'h9
`define TG_CNT_W 21
`define TG_CHG_CYCLES 3'h4

`endif

//--- rtl/tg_guard.v
/*
 * Timeout guard with protected control register and reset-cause flags.
 * Assumes nrst is the power-up reset of this block, and that the
 * oscillator tick, restart, acknowledge and reset events are
 * one-cycle pulses synchronous to sys_clk.
 */
`timescale 1ns/1ps
`include "tg_consts.vh"

module tg_guard #(
    parameter [20:0] TOUT_BASE = `TG_TOUT_BASE
) (
    sys_clk,
    nrst,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    guard_osc_tick,
    guard_restart,
    guard_irq_ack,
    guard_force_fuse,
    pin_rst_evt,
    undervolt_evt,
    scan_rst_evt,
    guard_irq,
    guard_sys_rst
);
    input wire sys_clk;
    input wire nrst;
    input wire [7:0] reg_addr;
    input wire [7:0] reg_wdata;
    input wire reg_wr;
    input wire reg_rd;
    output wire [7:0] reg_rdata;
    input wire guard_osc_tick;
    input wire guard_restart;
    input wire guard_irq_ack;
    input wire guard_force_fuse;
    input wire pin_rst_evt;
    input wire undervolt_evt;
    input wire scan_rst_evt;
    output wire guard_irq;
    output wire guard_sys_rst;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    localparam [`TG_CAUSE_W-1:0] CAUSE_RST = `TG_CAUSE_RST;

    reg guard_irq_flag_r;
    reg guard_irq_flag_nxt;
    reg guard_irq_en_r;
    reg guard_irq_en_nxt;
    reg guard_reset_en_r;
    reg guard_reset_en_nxt;
    reg [3:0] guard_period_sel_r;
    reg [3:0] guard_period_sel_nxt;
    reg [`TG_CAUSE_W-1:0] cause_r;
    reg [7:0] rdata_r;
    reg [7:0] rdata_nxt;
    reg irq_r;
    reg sys_rst_r;

    wire wr_ctrl;
    wire wr_cause;
    wire guard_change_en;
    wire irq_en_eff;
    wire reset_en_eff;
    wire running;
    wire expire;
    wire wd_rst;
    wire wd_irq_set;
    wire any_rst;
    wire [20:0] tout_lim;
    wire [20:0] tout_lim_m1;
    wire [3:0] wr_period;
    wire [`TG_CAUSE_W-1:0] cause_evt;
    wire [7:0] ctrl_view;
    wire [7:0] cause_view;

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    assign wr_ctrl = reg_wr & (reg_addr == `TG_CTRL_OFS);
    assign wr_cause = reg_wr & (reg_addr == `TG_CAUSE_OFS);
    assign wr_period = {reg_wdata[`TG_PER_HI_BIT],
                        reg_wdata[`TG_PER_LO_MSB:0]};

    // ---------------------------------------------------------------
    // Effective mode bits
    // ---------------------------------------------------------------
    // Fuse forces reset-only operation
    assign irq_en_eff = guard_irq_en_r & ~guard_force_fuse;
    // Guard reset flag and fuse both hold reset enable high
    assign reset_en_eff = guard_reset_en_r
                          | cause_r[`TG_GUARD_BIT]
                          | guard_force_fuse;
    assign running = irq_en_eff | reset_en_eff;

    // ---------------------------------------------------------------
    // Timeout length
    // ---------------------------------------------------------------
    // Base tick count doubled per step of the period code
    assign tout_lim = TOUT_BASE << guard_period_sel_r;
    assign tout_lim_m1 = tout_lim - 21'h000001;

    // ---------------------------------------------------------------
    // Tick counter
    // ---------------------------------------------------------------
    tg_tick_cnt u_cnt (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .run(running),
        .restart(guard_restart),
        .tick(guard_osc_tick),
        .lim_m1(tout_lim_m1),
        .expire(expire)
    );

    // ---------------------------------------------------------------
    // Expiry action
    // ---------------------------------------------------------------
    // Reset when reset enabled, unless combined mode still owes
    // its first interrupt
    assign wd_rst = expire & reset_en_eff
                    & ~(irq_en_eff & ~guard_irq_flag_r);
    // Interrupt when enabled and no reset is taken
    assign wd_irq_set = expire & irq_en_eff & ~wd_rst;

    // Any system reset returns the control bits except reset enable to their start values
    assign any_rst = wd_rst | pin_rst_evt | undervolt_evt | scan_rst_evt;

    // ---------------------------------------------------------------
    // Change window
    // ---------------------------------------------------------------
    tg_chg_win u_win (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .open_req(wr_ctrl & reg_wdata[`TG_CHG_EN_BIT]),
        .sys_rst(any_rst),
        .win_open(guard_change_en)
    );

    // ---------------------------------------------------------------
    // Control register next values
    // ---------------------------------------------------------------
    always @* begin
        guard_irq_flag_nxt = guard_irq_flag_r;
        if (wr_ctrl && reg_wdata[`TG_IRQ_FLAG_BIT]) begin
            guard_irq_flag_nxt = 1'b0;
        end
        if (guard_irq_ack) begin
            guard_irq_flag_nxt = 1'b0;
        end
        if (wd_irq_set) begin
            guard_irq_flag_nxt = 1'b1;
        end
        if (any_rst) begin
            guard_irq_flag_nxt = 1'b0;
        end
    end

    always @* begin
        guard_irq_en_nxt = guard_irq_en_r;
        if (wr_ctrl) begin
            guard_irq_en_nxt = reg_wdata[`TG_IRQ_EN_BIT];
        end
        // Entering the vector in combined mode drops back to reset mode
        if (guard_irq_ack && reset_en_eff) begin
            guard_irq_en_nxt = 1'b0;
        end
        if (guard_force_fuse || any_rst) begin
            guard_irq_en_nxt = 1'b0;
        end
    end

    always @* begin
        guard_reset_en_nxt = guard_reset_en_r;
        if (wr_ctrl) begin
            if (reg_wdata[`TG_RST_EN_BIT]) begin
                guard_reset_en_nxt = 1'b1;
            end else if (guard_change_en) begin
                // Clearing only inside the open window
                guard_reset_en_nxt = 1'b0;
            end
        end
    end

    always @* begin
        guard_period_sel_nxt = guard_period_sel_r;
        // Writes move the period only inside the window, any reset returns it to code 0; reserved codes ignored
        if (wr_ctrl && guard_change_en
            && wr_period <= `TG_PER_MAX) begin
            guard_period_sel_nxt = wr_period;
        end
        if (any_rst) begin
            guard_period_sel_nxt = `TG_PER_RST;
        end
    end

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            guard_irq_flag_r <= 1'b0;
            guard_irq_en_r <= 1'b0;
            guard_reset_en_r <= `TG_CTRL_RST_EN;
            guard_period_sel_r <= `TG_PER_RST;
        end else begin
            guard_irq_flag_r <= guard_irq_flag_nxt;
            guard_irq_en_r <= guard_irq_en_nxt;
            guard_reset_en_r <= guard_reset_en_nxt;
            guard_period_sel_r <= guard_period_sel_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Reset-cause flags
    // ---------------------------------------------------------------
    // Power-up flag has no setting event after nrst
    assign cause_evt[`TG_SCAN_BIT] = scan_rst_evt;
    assign cause_evt[`TG_GUARD_BIT] = wd_rst;
    assign cause_evt[`TG_UNDERVOLT_BIT] = undervolt_evt;
    assign cause_evt[`TG_PIN_BIT] = pin_rst_evt;
    assign cause_evt[`TG_POWERUP_BIT] = 1'b0;

    genvar gi;
    generate
        for (gi = 0; gi < `TG_CAUSE_W; gi = gi + 1) begin : g_cause
            // Power-up reset loads start value; set beats written zero
            always @(posedge sys_clk or negedge nrst) begin
                if (!nrst) begin
                    cause_r[gi] <= CAUSE_RST[gi];
                end else if (cause_evt[gi]) begin
                    cause_r[gi] <= 1'b1;
                end else if (wr_cause && !reg_wdata[gi]) begin
                    cause_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    assign ctrl_view = {guard_irq_flag_r, irq_en_eff,
                        guard_period_sel_r[3], guard_change_en,
                        reset_en_eff, guard_period_sel_r[2:0]};
    assign cause_view = {3'h0, cause_r};

    always @* begin
        rdata_nxt = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `TG_CTRL_OFS: begin
                    rdata_nxt = ctrl_view;
                end
                `TG_CAUSE_OFS: begin
                    rdata_nxt = cause_view;
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Output registers
    // ---------------------------------------------------------------
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 8'h00;
            irq_r <= 1'b0;
            sys_rst_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            // Level request, usable as a wake source
            irq_r <= guard_irq_flag_nxt & guard_irq_en_nxt;
            sys_rst_r <= wd_rst;
        end
    end

    assign reg_rdata = rdata_r;
    assign guard_irq = irq_r;
    assign guard_sys_rst = sys_rst_r;

endmodule

//--- rtl/tg_tick_cnt.v
/*
 * Oscillator tick counter with restart and expiry detection.
 * Assumes tick is a one-cycle strobe per oscillator cycle.
 */
`timescale 1ns/1ps
`include "tg_consts.vh"

module tg_tick_cnt (
    sys_clk,
    nrst,
    run,
    restart,
    tick,
    lim_m1,
    expire
);
    input wire sys_clk;
    input wire nrst;
    input wire run;
    input wire restart;
    input wire tick;
    input wire [20:0] lim_m1;
    output wire expire;

    reg [20:0] cnt_r;
    reg [20:0] cnt_nxt;

    // Restart beats a coinciding tick
    assign expire = run & tick & ~restart & (cnt_r >= lim_m1);

    always @* begin
        cnt_nxt = cnt_r;
        if (!run || restart || expire) begin
            cnt_nxt = 21'h000000;
        end else if (tick) begin
            cnt_nxt = cnt_r + 21'h000001;
        end
    end

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 21'h000000;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule

//--- tb/tb.sv
/* Self-checking bench for tg_guard.
   Assumes the oscillator model drives the tick input. */
`timescale 1ns/1ps
module tb;
    localparam [20:0] BASE = 21'h000004;
    localparam integer DIV = 16;
    reg sys_clk = 1'b0;
    reg nrst = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [4:0] pls = 5'h00;
    reg fuse = 1'b0;
    reg slow = 1'b0;
    wire [7:0] reg_rdata;
    wire tick;
    wire irq;
    wire srst;
    integer fail_count = 0;
    integer compares = 0;
    integer rst_seen = 0;
    integer i;
    integer n;
    integer cyc;
    reg [7:0] cause;
    reg [7:0] v;
    tg_osc_model #(.DIV(DIV)) osc_u (.sys_clk(sys_clk), .nrst(nrst),
        .slow(slow), .tick(tick));
    tg_guard #(.TOUT_BASE(BASE)) dut_u (.sys_clk(sys_clk), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .guard_osc_tick(tick),
        .guard_restart(pls[0]), .guard_irq_ack(pls[1]),
        .guard_force_fuse(fuse), .pin_rst_evt(pls[2]),
        .undervolt_evt(pls[3]), .scan_rst_evt(pls[4]),
        .guard_irq(irq), .guard_sys_rst(srst));
    initial forever #50 sys_clk = ~sys_clk;
    always @(negedge sys_clk) if (srst === 1'b1) rst_seen = rst_seen + 1;
    task wrap_up;
        begin
            $display("compares=%0d fail_count=%0d", compares, fail_count);
            if (fail_count == 0 && compares > 0) begin
                $display("[ PASS ]");
            end else begin
                $display("[ FAIL ]");
            end
            $finish;
        end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge sys_clk);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge sys_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [7:0] exp);
        begin
            @(posedge sys_clk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge sys_clk);
            reg_rd <= 1'b0;
            #1;
            chk(reg_rdata, exp);
        end
    endtask
    task pulse(input [4:0] p);
        begin
            @(posedge sys_clk);
            pls <= p;
            @(posedge sys_clk);
            pls <= 5'h00;
        end
    endtask
    task prot(input [7:0] o, input [7:0] d);
        begin
            wr(8'h60, o);
            wr(8'h60, d);
        end
    endtask
    task wait_out(input s);
        begin
            cyc = 0;
            while ((s ? srst : irq) !== 1'b1 && cyc < 2000) begin
                @(posedge sys_clk);
                #1;
                cyc = cyc + 1;
            end
            chk(s ? srst : irq, 1'b1);
        end
    endtask
    function [7:0] in_time(input integer c, input integer per,
        input integer d);
        integer e;
        begin
            e = BASE * (1 << per) * d;
            in_time = (c >= e - d && c <= e + 2) ? 8'h01 : 8'h00;
        end
    endfunction
    initial begin
        #2000000;
        fail_count = fail_count + 1;
        wrap_up;
    end
    initial begin
        v = $urandom(67563);
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(8'h35, 8'h01);
        rd(8'h60, 8'h00);
        wr(8'h7e, 8'hff);
        rd(8'h7e, 8'h00);
        cause = 8'h01;
        for (i = 0; i < 3; i = i + 1) begin
            pulse(5'h04 << i);
            cause = cause | ((i == 2) ? 8'h10 : (8'h02 << i));
            rd(8'h35, cause);
        end
        repeat (3) begin
            v = $urandom;
            wr(8'h35, v);
            cause = cause & v;
            rd(8'h35, cause);
        end
        wr(8'h35, 8'h00);
        slow <= 1'b1;
        wr(8'h60, 8'h40);
        pulse(5'h01);
        n = rst_seen;
        wait_out(1'b0);
        chk(in_time(cyc, 0, 2 * DIV), 8'h01);
        chk((rst_seen == n) ? 8'h01 : 8'h00, 8'h01);
        slow <= 1'b0;
        pulse(5'h02);
        rd(8'h60, 8'h40);
        wait_out(1'b0);
        wr(8'h60, 8'hc0);
        rd(8'h60, 8'h40);
        chk(irq, 8'h00);
        wr(8'h60, 8'h00);
        pulse(5'h01);
        wr(8'h60, 8'h0a);
        rd(8'h60, 8'h08);
        prot(8'h18, 8'h0b);
        rd(8'h60, 8'h1b);
        wr(8'h60, 8'h03);
        rd(8'h60, 8'h0b);
        wr(8'h60, 8'h1b);
        rd(8'h60, 8'h1b);
        repeat (4) @(posedge sys_clk);
        wr(8'h60, 8'h00);
        rd(8'h60, 8'h0b);
        prot(8'h1b, 8'h2b);
        rd(8'h60, 8'h1b);
        pulse(5'h01);
        prot(8'h1b, 8'h09);
        n = rst_seen;
        repeat (3) begin
            repeat (100) @(posedge sys_clk);
            pulse(5'h01);
        end
        chk((rst_seen == n) ? 8'h01 : 8'h00, 8'h01);
        wait_out(1'b1);
        chk(in_time(cyc, 1, DIV), 8'h01);
        rd(8'h35, 8'h08);
        rd(8'h60, 8'h08);
        prot(8'h18, 8'h00);
        rd(8'h60, 8'h18);
        wr(8'h35, 8'h00);
        prot(8'h18, 8'h00);
        rd(8'h60, 8'h10);
        for (i = 0; i < 2; i = i + 1) begin
            wr(8'h60, 8'h48);
            pulse(5'h01);
            wait_out(1'b0);
            if (i == 0) begin
                rd(8'h60, 8'hc8);
                wait_out(1'b1);
                rd(8'h60, 8'h08);
            end else begin
                pulse(5'h02);
                rd(8'h60, 8'h08);
                wait_out(1'b1);
            end
        end
        @(posedge sys_clk);
        fuse <= 1'b1;
        wr(8'h60, 8'h40);
        rd(8'h60, 8'h08);
        pulse(5'h01);
        wait_out(1'b1);
        fuse <= 1'b0;
        pulse(5'h04);
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(8'h35, 8'h01);
        rd(8'h60, 8'h00);
        wrap_up;
    end
endmodule

//--- tb/tg_guard_properties.sv
/* Port checker for tg_guard, bound into every instance.
   Assumes it sees only the top-level ports of the guard. */
`timescale 1ns/1ps
module tg_guard_props #(
    parameter [20:0] TOUT_BASE = 21'h000800
) (
    input wire sys_clk,
    input wire nrst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire guard_osc_tick,
    input wire guard_restart,
    input wire guard_irq_ack,
    input wire guard_force_fuse,
    input wire pin_rst_evt,
    input wire undervolt_evt,
    input wire scan_rst_evt,
    input wire guard_irq,
    input wire guard_sys_rst
);
    reg [2:0] age_r;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    // Cycles since the change window was last opened, saturating
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            age_r <= 3'h7;
        end else if (reg_wr && reg_addr == 8'h60 && reg_wdata[4]) begin
            age_r <= 3'h1;
        end else if (pin_rst_evt || undervolt_evt || scan_rst_evt) begin
            age_r <= 3'h7;
        end else if (age_r != 3'h7) begin
            age_r <= age_r + 3'h1;
        end
    end
    AST_RST_PULSE:
        assert property (guard_sys_rst |=> !guard_sys_rst)
        else $error("guard reset pulse too long");
    AST_RST_ON_TICK:
        assert property (guard_sys_rst |->
            $past(guard_osc_tick) && !$past(guard_restart))
        else $error("guard reset without a final tick");
    AST_RESTART_HOLD:
        assert property (guard_restart |=> !guard_sys_rst [*4])
        else $error("guard reset too soon after restart");
    AST_FUSE_NO_IRQ:
        assert property ($past(guard_force_fuse) && guard_force_fuse
            |-> !guard_irq)
        else $error("interrupt while fuse forces reset mode");
    AST_FUSE_CTRL:
        assert property ($past(reg_rd) && $past(reg_addr) == 8'h60
            && $past(guard_force_fuse) |-> reg_rdata[3] && !reg_rdata[6])
        else $error("fuse does not lock the enables");
    AST_WIN_CLOSED:
        assert property ($past(reg_rd) && $past(reg_addr) == 8'h60
            && $past(age_r) >= 3'h5 |-> !reg_rdata[4])
        else $error("change window still open");
    AST_CAUSE_TOP:
        assert property ($past(reg_rd) && $past(reg_addr) == 8'h35
            |-> reg_rdata[7:5] == 3'h0)
        else $error("cause register upper bits not zero");
    AST_ACK_DROPS:
        assert property (guard_irq_ack && !guard_osc_tick |=> !guard_irq)
        else $error("interrupt stays after acknowledge");
endmodule

bind tg_guard tg_guard_props #(.TOUT_BASE(TOUT_BASE)) props_u (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .guard_osc_tick(guard_osc_tick),
    .guard_restart(guard_restart),
    .guard_irq_ack(guard_irq_ack),
    .guard_force_fuse(guard_force_fuse),
    .pin_rst_evt(pin_rst_evt),
    .undervolt_evt(undervolt_evt),
    .scan_rst_evt(scan_rst_evt),
    .guard_irq(guard_irq),
    .guard_sys_rst(guard_sys_rst)
);

//--- tb/tg_osc_model.sv
/* Stand-in for the guard oscillator: one tick pulse per period.
   Assumes the bench may ask for a slow rate at any time. */
`timescale 1ns/1ps
module tg_osc_model #(
    parameter integer DIV = 16
) (
    input wire sys_clk,
    input wire nrst,
    input wire slow,
    output reg tick
);
    integer cnt;
    // Tick every DIV cycles, or twice that when slow
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 0;
            tick <= 1'b0;
        end else begin
            tick <= (cnt == 0);
            cnt <= (cnt >= (slow ? 2 * DIV : DIV) - 1) ? 0 : cnt + 1;
        end
    end
endmodule
